// [logic/msp_pkg.sv]
package msp_pkg;

  // system clock runs at five times the metering core's nominal master clock
  localparam int SYS_CLK_HZ = 50_000_000;
  localparam int MCLK_NOM_HZ = 10_000_000;

  // least wait between a read command byte and the first data bit
  localparam int RD_WAIT_NS = 1100;
  localparam int RD_WAIT_CYC = (RD_WAIT_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;

  // serial framing
  localparam int BYTE_BITS = 8;
  localparam int CMD_WRITE_BIT = 7;
  localparam int ADDR_BITS = 7;

  // interrupt sources
  localparam int NUM_IRQ_SRC = 3;
  localparam int IRQ_ACT_HALF = 0;
  localparam int IRQ_APP_HALF = 1;
  localparam int IRQ_WAVE_RDY = 2;
  localparam int WAVE_MAX_SPS = 26_000;

  // synchroniser depth on pin inputs
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    MSP_ST_CMD,
    MSP_ST_WR,
    MSP_ST_RD
  } msp_state_e;

endpackage

// [logic/msp_sync.sv]
`timescale 1ns/1ps
module msp_sync #(
  parameter int WIDTH = 1
) (
  // clocking
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // first stage is read by the second stage only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '1;
      q <= '1;
    end else if (clk_en) begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// [logic/msp_serial_port.sv]
`timescale 1ns/1ps
module msp_serial_port #(
  parameter int NUM_SRC = msp_pkg::NUM_IRQ_SRC
) (
  // clocking
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // serial pins
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic din_pin,
  output logic dout_o,
  output logic dout_oe_n,
  // interrupt pin, open drain
  output logic irq_n_o,
  output logic irq_oe_n,
  // core register port
  output logic [msp_pkg::ADDR_BITS-1:0] reg_addr,
  output logic wr_valid,
  output logic [msp_pkg::BYTE_BITS-1:0] wr_data,
  output logic rd_req,
  input wire logic [msp_pkg::BYTE_BITS-1:0] rd_data,
  output logic rd_early,
  // interrupt sources
  input wire logic [NUM_SRC-1:0] irq_event,
  input wire logic [NUM_SRC-1:0] irq_mask,
  input wire logic [NUM_SRC-1:0] irq_clear,
  output logic [NUM_SRC-1:0] irq_status
);

  localparam int WAIT_W = $clog2(msp_pkg::RD_WAIT_CYC + 1);
  localparam logic [WAIT_W-1:0] WAIT_LOAD = WAIT_W'(msp_pkg::RD_WAIT_CYC);
  localparam logic [2:0] LAST_BIT = 3'(msp_pkg::BYTE_BITS - 1);

  logic [2:0] pin_s;
  logic cs_n_s;
  logic sclk_s;
  logic din_s;
  logic sclk_d_r;
  logic sclk_fall;
  logic sclk_rise;
  logic byte_done;
  logic cmd_is_rd;
  logic cmd_done;
  logic wr_byte_done;
  logic rd_byte_done;
  logic [msp_pkg::BYTE_BITS-1:0] rx_nxt;
  logic [msp_pkg::BYTE_BITS-1:0] rx_sr_r;
  logic [msp_pkg::BYTE_BITS-1:0] tx_sr_r;
  logic [2:0] bit_cnt_r;
  logic [WAIT_W-1:0] wait_cnt_r;
  logic dout_r;
  logic irq_pend_r;
  msp_pkg::msp_state_e state_r;

  // pins come from the host's domain: two flops before any use
  msp_sync #(
    .WIDTH(3)
  ) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .d({cs_n_pin, sclk_pin, din_pin}),
    .q(pin_s)
  );

  assign cs_n_s = pin_s[2];
  assign sclk_s = pin_s[1];
  assign din_s = pin_s[0];

  // edges only count while selected
  assign sclk_fall = !cs_n_s && sclk_d_r && !sclk_s;
  assign sclk_rise = !cs_n_s && !sclk_d_r && sclk_s;
  assign rx_nxt = {rx_sr_r[msp_pkg::BYTE_BITS-2:0], din_s};
  assign byte_done = sclk_fall && (bit_cnt_r == LAST_BIT);

  // phase of the byte that completes on this edge
  assign cmd_is_rd = !rx_nxt[msp_pkg::CMD_WRITE_BIT];
  assign cmd_done = byte_done && state_r == msp_pkg::MSP_ST_CMD;
  assign wr_byte_done = byte_done && state_r == msp_pkg::MSP_ST_WR;
  assign rd_byte_done = byte_done && state_r == msp_pkg::MSP_ST_RD;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_d_r <= 1'b1;
    end else if (clk_en) begin
      sclk_d_r <= sclk_s;
    end
  end

  // receive shifter and bit count
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_sr_r <= 8'h00;
      bit_cnt_r <= 3'h0;
    end else if (clk_en) begin
      if (cs_n_s) begin
        bit_cnt_r <= 3'h0;
      end else if (sclk_fall) begin
        rx_sr_r <= rx_nxt;
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
    end
  end

  // transfer phase: command byte first, then data bytes until deselect
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= msp_pkg::MSP_ST_CMD;
      reg_addr <= '0;
    end else if (clk_en) begin
      if (cs_n_s) begin
        state_r <= msp_pkg::MSP_ST_CMD;
      end else begin
        unique case (state_r)
          msp_pkg::MSP_ST_CMD: begin
            if (byte_done) begin
              reg_addr <= rx_nxt[msp_pkg::ADDR_BITS-1:0];
              state_r <= cmd_is_rd ? msp_pkg::MSP_ST_RD : msp_pkg::MSP_ST_WR;
            end
          end
          // data phases last until deselect
          msp_pkg::MSP_ST_WR, msp_pkg::MSP_ST_RD: begin
            state_r <= state_r;
          end
          // the spare two-bit code falls back to awaiting a command
          default: begin
            state_r <= msp_pkg::MSP_ST_CMD;
          end
        endcase
      end
    end
  end

  // core strobes, one cycle each
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_valid <= 1'b0;
      wr_data <= 8'h00;
      rd_req <= 1'b0;
    end else if (clk_en) begin
      wr_valid <= wr_byte_done;
      rd_req <= (cmd_done && cmd_is_rd) || rd_byte_done;
      if (wr_byte_done) begin
        wr_data <= rx_nxt;
      end
    end
  end

  // least gap between a read command and the first data rise, counted down
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wait_cnt_r <= '0;
    end else if (clk_en) begin
      if (cmd_done && cmd_is_rd) begin
        wait_cnt_r <= WAIT_LOAD;
      end else if (wait_cnt_r != '0) begin
        wait_cnt_r <= wait_cnt_r - WAIT_W'(1);
      end
    end
  end

  // flags a host that starts clocking read data too soon; the core may not have its byte yet
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_early <= 1'b0;
    end else if (clk_en) begin
      rd_early <= sclk_rise && state_r == msp_pkg::MSP_ST_RD && bit_cnt_r == 3'h0 && wait_cnt_r != '0;
    end
  end

  // transmit: read byte taken from the core at the first rising edge of each byte
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_sr_r <= 8'h00;
      dout_r <= 1'b0;
    end else if (clk_en) begin
      if (sclk_rise && state_r == msp_pkg::MSP_ST_RD) begin
        if (bit_cnt_r == 3'h0) begin
          dout_r <= rd_data[msp_pkg::BYTE_BITS-1];
          tx_sr_r <= {rd_data[msp_pkg::BYTE_BITS-2:0], 1'b0};
        end else begin
          dout_r <= tx_sr_r[msp_pkg::BYTE_BITS-1];
          tx_sr_r <= {tx_sr_r[msp_pkg::BYTE_BITS-2:0], 1'b0};
        end
      end
    end
  end

  assign dout_o = dout_r;
  assign dout_oe_n = !(state_r == msp_pkg::MSP_ST_RD && !cs_n_s);

  // sticky status; an event in the clearing cycle survives the clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_status <= '0;
    end else if (clk_en) begin
      irq_status <= (irq_status & ~irq_clear) | irq_event;
    end
  end

  // registered so the open-drain enable never glitches on mask changes
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_pend_r <= 1'b0;
    end else if (clk_en) begin
      irq_pend_r <= |(irq_status & irq_mask);
    end
  end

  // open drain: only ever pulls low, never drives high
  assign irq_n_o = 1'b0;
  assign irq_oe_n = !irq_pend_r;

  // the whole port runs on sys_clk, at five times the nominal master clock rate

endmodule

// [dv/msp_assertions.sv]
`timescale 1ns/1ps
module msp_chk #(parameter int NUM_SRC = 3) (
  // clocking
  input wire logic sys_clk,
  input wire logic nrst,
  // pins
  input wire logic cs_n_pin,
  input wire logic dout_oe_n,
  input wire logic irq_n_o,
  input wire logic irq_oe_n,
  // core side
  input wire logic wr_valid,
  input wire logic rd_req,
  input wire logic [NUM_SRC-1:0] irq_event,
  input wire logic [NUM_SRC-1:0] irq_mask,
  input wire logic [NUM_SRC-1:0] irq_clear,
  input wire logic [NUM_SRC-1:0] irq_status
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // mask must be settled first, and a clear right after the event may release the line again
  sequence s_set;
    irq_event[0] && irq_mask[0] && $stable(irq_mask) ##1 irq_mask[0] && !irq_clear[0];
  endsequence
  AST_CS_QUIET: assert property (cs_n_pin [*4] |-> !wr_valid && !rd_req) else $error("strobe deselected");
  AST_OE_IDLE: assert property (cs_n_pin [*4] |-> dout_oe_n) else $error("dout driven deselected");
  AST_OE_WR: assert property (wr_valid |-> dout_oe_n) else $error("dout driven in write");
  AST_OE_RD: assert property (rd_req |-> !dout_oe_n) else $error("dout released in read");
  AST_OD_LOW: assert property (!irq_n_o) else $error("irq data not low");
  AST_IRQ_SET: assert property (s_set |=> !irq_oe_n) else $error("irq not pulled");
  AST_MASK: assert property ((irq_mask == '0) [*3] |-> irq_oe_n) else $error("masked irq pulled");
  AST_STAT: assert property (irq_event[2] |=> irq_status[2]) else $error("status not set");
endmodule
bind msp_serial_port msp_chk #(.NUM_SRC(NUM_SRC)) chk_u (.sys_clk(sys_clk), .nrst(nrst), .cs_n_pin(cs_n_pin),
  .dout_oe_n(dout_oe_n), .irq_n_o(irq_n_o), .irq_oe_n(irq_oe_n), .wr_valid(wr_valid), .rd_req(rd_req),
  .irq_event(irq_event), .irq_mask(irq_mask), .irq_clear(irq_clear), .irq_status(irq_status));

// [dv/msp_host.sv]
`timescale 1ns/1ps
module msp_host (
  // clock
  input wire logic sys_clk,
  // serial wires
  output logic cs_n = 1'b1,
  output logic sclk = 1'b1,
  output logic din = 1'b0,
  input wire logic dout
);
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // din moves at the rise so it is settled well before the capturing fall
  task automatic shift(input int nb, input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i > 7 - nb; i--) begin
      sclk <= 1'b1;
      din <= tx[i];
      wait_cyc(4);
      sclk <= 1'b0;
      wait_cyc(4);
      rx[i] = dout;
    end
  endtask
  task automatic start();
    cs_n <= 1'b0;
    wait_cyc(4);
  endtask
  task automatic stop();
    sclk <= 1'b1;
    wait_cyc(4);
    cs_n <= 1'b1;
    wait_cyc(8);
  endtask
  task automatic frame(input logic [7:0] cmd, input logic [7:0] tx, output logic [7:0] rx);
    logic [7:0] junk;
    start();
    shift(8, cmd, junk);
    if (!cmd[7])
      wait_cyc(msp_pkg::RD_WAIT_CYC + 4);
    shift(8, tx, rx);
    stop();
  endtask
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
  typedef struct packed {logic [7:0] cmd; logic [7:0] dat;} msp_row_s;
  logic sys_clk = 1'b0, nrst = 1'b0, tgl = 1'b0;
  logic [7:0] rd_data = 8'h00, wr_data, wr_last, rx;
  logic [2:0] ev = 3'h0, mask = 3'h0, clr = 3'h0, irq_status;
  logic [6:0] reg_addr;
  logic dout_o, dout_oe_n, irq_n_o, irq_oe_n, wr_valid, rd_req, rd_early, cs_n, sclk, din;
  int errors = 0, cmp_count = 0, wr_cnt = 0, rd_cnt = 0, early_cnt = 0, n;
  // released dout shows a moving pattern, irq has a pull-up
  wire dout_w = dout_oe_n ? tgl : dout_o;
  wire irq_w = irq_oe_n ? 1'b1 : irq_n_o;
  msp_row_s rows [4] = '{'{8'h85, 8'h3c}, '{8'hff, 8'hc3}, '{8'h05, 8'ha5}, '{8'h7f, 8'h5a}};
  msp_serial_port dut_u (.sys_clk(sys_clk), .nrst(nrst), .clk_en(1'b1), .cs_n_pin(cs_n), .sclk_pin(sclk),
    .din_pin(din), .dout_o(dout_o), .dout_oe_n(dout_oe_n), .irq_n_o(irq_n_o), .irq_oe_n(irq_oe_n),
    .reg_addr(reg_addr), .wr_valid(wr_valid), .wr_data(wr_data), .rd_req(rd_req), .rd_data(rd_data),
    .rd_early(rd_early), .irq_event(ev), .irq_mask(mask), .irq_clear(clr), .irq_status(irq_status));
  msp_host host_u (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout_w));
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    tgl <= ~tgl;
  always @(posedge sys_clk)
    if (rd_req === 1'b1)
      rd_cnt <= rd_cnt + 1;
  always @(posedge sys_clk)
    if (rd_early === 1'b1)
      early_cnt <= early_cnt + 1;
  always @(posedge sys_clk)
    if (wr_valid === 1'b1) begin
      wr_last <= wr_data;
      wr_cnt <= wr_cnt + 1;
    end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000;
    errors++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    chk("rst_oe", 8'h1, 8'(dout_oe_n));
    chk("rst_irq", 8'h1, 8'(irq_oe_n));
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    foreach (rows[i]) begin
      rd_data <= rows[i].dat;
      host_u.frame(rows[i].cmd, rows[i].cmd[7] ? rows[i].dat : 8'h00, rx);
      chk("addr", {1'b0, rows[i].cmd[6:0]}, {1'b0, reg_addr});
      if (rows[i].cmd[7])
        chk("wr", rows[i].dat, wr_last);
      else
        chk("rd", rows[i].dat, rx);
    end
    // two read rows, each a command byte and one data byte
    chk("rd_req", 8'h04, 8'(rd_cnt));
    chk("no_early", 8'h00, 8'(early_cnt));
    $display("serial rows done");
    // clocking with chip select high must leave the port untouched
    n = wr_cnt;
    host_u.shift(8, 8'h80, rx);
    host_u.shift(8, 8'h11, rx);
    host_u.stop();
    chk("desel", 8'(n), 8'(wr_cnt));
    host_u.start();
    host_u.shift(4, 8'hff, rx);
    host_u.stop();
    host_u.frame(8'h81, 8'h66, rx);
    chk("abort_addr", 8'h01, {1'b0, reg_addr});
    chk("abort_wr", 8'h66, wr_last);
    // data clocked straight after a read command comes too soon
    host_u.start();
    host_u.shift(8, 8'h05, rx);
    host_u.shift(8, 8'h00, rx);
    host_u.stop();
    chk("early", 8'h01, 8'(early_cnt));
    $display("select tests done");
    for (int s = 0; s < 3; s++) begin
      mask <= 3'(1 << s);
      @(posedge sys_clk);
      ev <= 3'(1 << s);
      @(posedge sys_clk);
      ev <= 3'h0;
      repeat (3) @(posedge sys_clk);
      chk("irq_on", 8'h0, 8'(irq_w));
      mask <= 3'h0;
      repeat (3) @(posedge sys_clk);
      chk("irq_masked", 8'h1, 8'(irq_w));
      chk("irq_stat", 8'(1 << s), 8'(irq_status));
      clr <= 3'h7;
      @(posedge sys_clk);
      clr <= 3'h0;
      @(posedge sys_clk);
    end
    // an event in the clearing cycle must survive the clear
    ev <= 3'h2;
    clr <= 3'h7;
    @(posedge sys_clk);
    ev <= 3'h0;
    clr <= 3'h0;
    @(posedge sys_clk);
    chk("irq_setwin", 8'h02, 8'(irq_status));
    $display("irq tests done");
    // reset in the middle of a read phase, then a clean frame
    host_u.start();
    host_u.shift(8, 8'h05, rx);
    chk("rd_oe", 8'h0, 8'(dout_oe_n));
    nrst <= 1'b0;
    @(posedge sys_clk);
    chk("rst2_oe", 8'h1, 8'(dout_oe_n));
    chk("rst2_addr", 8'h00, {1'b0, reg_addr});
    chk("rst2_stat", 8'h00, 8'(irq_status));
    nrst <= 1'b1;
    host_u.stop();
    host_u.frame(8'h92, 8'h77, rx);
    chk("rst2_wr_addr", 8'h12, {1'b0, reg_addr});
    chk("rst2_wr", 8'h77, wr_last);
    $display("reset tests done");
    end_sim();
  end
endmodule
